// >>> design/btl_regs.svh
`ifndef BTL_REGS_SVH
`define BTL_REGS_SVH

// Register byte offsets
`define BTL_OFS_DEF        8'h00
`define BTL_OFS_ADDR_LOW   8'h04
`define BTL_OFS_ADDR_HIGH  8'h08
`define BTL_OFS_PC_BASE    8'h0C
`define BTL_OFS_PC_MASK    8'h10
`define BTL_OFS_DATA_VAL   8'h14
`define BTL_OFS_STATUS     8'h18
`define BTL_OFS_CLEAR      8'h1C
`define BTL_OFS_IRQ_EN     8'h20
`define BTL_OFS_STATE      8'h24

// Trigger definition layout
`define BTL_DEF_RESET      32'h0000_0000
`define BTL_DEF_WMASK      32'hFFFF_3FFF
`define BTL_RESP_MSB       31
`define BTL_RESP_LSB       30
`define BTL_L2_MSB         29
`define BTL_L2_LSB         16
`define BTL_L1_MSB         13
`define BTL_L1_LSB         0

// Bit positions inside one 14-bit level field
`define BTL_LV_GLOBAL_EN   13
`define BTL_LV_LONGWORD    12
`define BTL_LV_LOW_WORD    11
`define BTL_LV_UPPER_WORD  10
`define BTL_LV_BYTE0       9
`define BTL_LV_BYTE1       8
`define BTL_LV_BYTE2       7
`define BTL_LV_BYTE3       6
`define BTL_LV_DATA_INV    5
`define BTL_LV_ADDR_OUT    4
`define BTL_LV_ADDR_RANGE  3
`define BTL_LV_ADDR_LOW    2
`define BTL_LV_PC_EN       1
`define BTL_LV_PC_INV      0

// Status bits
`define BTL_ST_LEVEL1      0
`define BTL_ST_TRIGGER     1
`define BTL_ST_WIDTH       2

// Debug data pin codes
`define BTL_DD_IDLE        4'h0
`define BTL_DD_TRIGGER     4'h8

`endif

// >>> design/btl_pkg.sv
package btl_pkg;

  typedef enum logic [1:0] {
    BTL_ARM_L1 = 2'b01,
    BTL_ARM_L2 = 2'b10
  } btl_state_t;

  typedef enum logic [1:0] {
    BTL_RESP_DISPLAY = 2'b00,
    BTL_RESP_HALT    = 2'b01,
    BTL_RESP_DBG_IRQ = 2'b10,
    BTL_RESP_RSVD    = 2'b11
  } btl_resp_t;

endpackage

// >>> design/btl_trigger.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "btl_regs.svh"

// Summary of operation
// - Definition holds response, level two, level one
// - Reset clears the whole trigger definition
// - Response: display, halt, debug interrupt, reserved
// - Completed trigger always shown on debug pins
// - Level enable zero blocks every breakpoint
// - Longword enable compares full core data
// - Any data enable arms data breakpoint
// - Word enables compare low or upper half
// - Byte enables compare their own byte
// - Invert flips the combined data compare result
// - Any address mode arms address breakpoint
// - Outside mode matches beyond low/high range
// - Range mode matches inclusive low/high range
// - Low mode matches address equal to low
// - PC enable switches PC matching on/off
// - PC invert selects inside or outside region
module btl_trigger
  import btl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        core_valid,
  input  wire logic [31:0] core_addr,
  input  wire logic [31:0] core_data_bus,
  input  wire logic [31:0] core_pc,
  output logic      [3:0]  debug_data_pins,
  output logic             halt_req,
  output logic             debug_irq,
  output logic             irq
);

  logic [31:0] breakpoint_trigger_definition_r;
  logic [31:0] address_breakpoint_low_r;
  logic [31:0] address_breakpoint_high_r;
  logic [31:0] pc_breakpoint_base_r;
  logic [31:0] pc_breakpoint_mask_r;
  logic [31:0] data_breakpoint_value_r;
  logic [`BTL_ST_WIDTH-1:0] status_r;
  logic [`BTL_ST_WIDTH-1:0] irq_en_r;
  btl_state_t  state_r;
  btl_state_t  state_nxt;

  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  ph_addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic [3:0]  pins_r;
  logic        halt_r;
  logic        dbg_irq_r;
  logic        irq_r;

  logic        addr_phase;
  logic        wr_def;
  logic        wr_clear;
  logic [13:0] cfg_l1;
  logic [13:0] cfg_l2;
  logic        two_level;
  logic        l1_hit;
  logic        l2_hit;
  logic        fire;
  logic        level1_event;
  btl_resp_t   resp;
  logic [3:0]  byte_eq;
  logic        addr_eq_low;
  logic        addr_in_range;
  logic        pc_in_region;
  logic [31:0] rd_mux;

  assign hrdata          = hrdata_r;
  assign hreadyout       = hreadyout_r;
  assign hresp           = 1'b0;
  assign debug_data_pins = pins_r;
  assign halt_req        = halt_r;
  assign debug_irq       = dbg_irq_r;
  assign irq             = irq_r;

  // Bus slave
  // Reads take one wait state so a write just before is always visible
  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (hready || rd_pend_r) begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      if (addr_phase) begin
        ph_addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= !(addr_phase && !hwrite);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ph_addr_r)
      `BTL_OFS_DEF:       rd_mux = breakpoint_trigger_definition_r;
      `BTL_OFS_ADDR_LOW:  rd_mux = address_breakpoint_low_r;
      `BTL_OFS_ADDR_HIGH: rd_mux = address_breakpoint_high_r;
      `BTL_OFS_PC_BASE:   rd_mux = pc_breakpoint_base_r;
      `BTL_OFS_PC_MASK:   rd_mux = pc_breakpoint_mask_r;
      `BTL_OFS_DATA_VAL:  rd_mux = data_breakpoint_value_r;
      `BTL_OFS_STATUS:    rd_mux = {30'h0000_0000, status_r};
      `BTL_OFS_IRQ_EN:    rd_mux = {30'h0000_0000, irq_en_r};
      `BTL_OFS_STATE:     rd_mux = {30'h0000_0000, state_r};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r && !hreadyout_r) begin
      hrdata_r <= rd_mux;
    end
  end

  assign wr_def   = wr_pend_r && (ph_addr_r == `BTL_OFS_DEF);
  assign wr_clear = wr_pend_r && (ph_addr_r == `BTL_OFS_CLEAR);

  // Trigger definition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      breakpoint_trigger_definition_r <= `BTL_DEF_RESET;
    end else if (wr_def) begin
      breakpoint_trigger_definition_r <= hwdata & `BTL_DEF_WMASK;
    end
  end

  // Comparison values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      address_breakpoint_low_r  <= 32'h0000_0000;
      address_breakpoint_high_r <= 32'h0000_0000;
      pc_breakpoint_base_r      <= 32'h0000_0000;
      pc_breakpoint_mask_r      <= 32'h0000_0000;
      data_breakpoint_value_r   <= 32'h0000_0000;
    end else if (wr_pend_r) begin
      case (ph_addr_r)
        `BTL_OFS_ADDR_LOW:  address_breakpoint_low_r  <= hwdata;
        `BTL_OFS_ADDR_HIGH: address_breakpoint_high_r <= hwdata;
        `BTL_OFS_PC_BASE:   pc_breakpoint_base_r      <= hwdata;
        `BTL_OFS_PC_MASK:   pc_breakpoint_mask_r      <= hwdata;
        `BTL_OFS_DATA_VAL:  data_breakpoint_value_r   <= hwdata;
        default: ;
      endcase
    end
  end

  // Comparators
  assign cfg_l1    = breakpoint_trigger_definition_r[`BTL_L1_MSB:`BTL_L1_LSB];
  assign cfg_l2    = breakpoint_trigger_definition_r[`BTL_L2_MSB:`BTL_L2_LSB];
  assign two_level = cfg_l2[`BTL_LV_GLOBAL_EN];
  assign resp      = btl_resp_t'(breakpoint_trigger_definition_r
                       [`BTL_RESP_MSB:`BTL_RESP_LSB]);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign byte_eq[gi] = core_data_bus[gi*8 +: 8]
                        == data_breakpoint_value_r[gi*8 +: 8];
    end
  endgenerate

  assign addr_eq_low   = core_addr == address_breakpoint_low_r;
  assign addr_in_range = (core_addr >= address_breakpoint_low_r)
                      && (core_addr <= address_breakpoint_high_r);
  // Mask bit set means that address bit is ignored
  assign pc_in_region  = ((core_pc ^ pc_breakpoint_base_r)
                        & ~pc_breakpoint_mask_r) == 32'h0000_0000;

  // One level completes when every armed breakpoint kind matches
  function automatic logic level_hit(
    input logic [13:0] cfg,
    input logic [3:0]  beq,
    input logic        a_low,
    input logic        a_rng,
    input logic        pc_in
  );
    logic [3:0] lanes;
    logic       d_en;
    logic       d_hit;
    logic       a_en;
    logic       a_hit;
    logic       p_hit;
    lanes = {4{cfg[`BTL_LV_LONGWORD]}}
          | {2'b00, {2{cfg[`BTL_LV_LOW_WORD]}}}
          | {{2{cfg[`BTL_LV_UPPER_WORD]}}, 2'b00}
          | {cfg[`BTL_LV_BYTE3], cfg[`BTL_LV_BYTE2],
             cfg[`BTL_LV_BYTE1], cfg[`BTL_LV_BYTE0]};
    d_en  = |lanes;
    d_hit = ((beq & lanes) == lanes) ^ cfg[`BTL_LV_DATA_INV];
    a_en  = cfg[`BTL_LV_ADDR_OUT] | cfg[`BTL_LV_ADDR_RANGE]
          | cfg[`BTL_LV_ADDR_LOW];
    a_hit = (cfg[`BTL_LV_ADDR_OUT] && !a_rng)
          | (cfg[`BTL_LV_ADDR_RANGE] && a_rng)
          | (cfg[`BTL_LV_ADDR_LOW] && a_low);
    p_hit = pc_in ^ cfg[`BTL_LV_PC_INV];
    level_hit = cfg[`BTL_LV_GLOBAL_EN]
             && (d_en || a_en || cfg[`BTL_LV_PC_EN])
             && (!d_en || d_hit)
             && (!a_en || a_hit)
             && (!cfg[`BTL_LV_PC_EN] || p_hit);
  endfunction

  assign l1_hit = core_valid
               && level_hit(cfg_l1, byte_eq, addr_eq_low, addr_in_range,
                            pc_in_region);
  assign l2_hit = core_valid
               && level_hit(cfg_l2, byte_eq, addr_eq_low, addr_in_range,
                            pc_in_region);

  // Sequencer
  always_comb begin
    state_nxt    = state_r;
    fire         = 1'b0;
    level1_event = 1'b0;
    case (state_r)
      BTL_ARM_L1: begin
        if (l1_hit) begin
          level1_event = 1'b1;
          if (two_level) begin
            state_nxt = BTL_ARM_L2;
          end else begin
            fire = 1'b1;
          end
        end
      end
      BTL_ARM_L2: begin
        if (l2_hit) begin
          fire      = 1'b1;
          state_nxt = BTL_ARM_L1;
        end
      end
      default: state_nxt = BTL_ARM_L1;
    endcase
  end

  // A new definition restarts the sequence at level one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= BTL_ARM_L1;
    end else if (wr_def) begin
      state_r <= BTL_ARM_L1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Responses, one-cycle pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_r    <= `BTL_DD_IDLE;
      halt_r    <= 1'b0;
      dbg_irq_r <= 1'b0;
    end else begin
      pins_r    <= fire ? (`BTL_DD_TRIGGER | {2'b00, resp})
                        : `BTL_DD_IDLE;
      halt_r    <= fire && (resp == BTL_RESP_HALT);
      dbg_irq_r <= fire && (resp == BTL_RESP_DBG_IRQ);
    end
  end

  // Sticky status; a set in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(wr_clear ? hwdata[`BTL_ST_WIDTH-1:0] : '0))
                | {fire, level1_event};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= '0;
    end else if (wr_pend_r && ph_addr_r == `BTL_OFS_IRQ_EN) begin
      irq_en_r <= hwdata[`BTL_ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & irq_en_r);
    end
  end

  // Checks
  sequence s_fire_halt;
    fire && resp == BTL_RESP_HALT;
  endsequence

  sequence s_fire_dbg;
    fire && resp == BTL_RESP_DBG_IRQ;
  endsequence

  sequence s_l1_then_l2;
    state_r == BTL_ARM_L1 && l1_hit && two_level && !wr_def
      ##1 state_r == BTL_ARM_L2;
  endsequence

  property p_def_reserved;
    @(posedge hclk) disable iff (!hresetn)
    breakpoint_trigger_definition_r[15:14] == 2'b00;
  endproperty
  a_def_reserved: assert property (p_def_reserved)
    else $error("definition bits 15:14 not zero");

  property p_def_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_def |=> breakpoint_trigger_definition_r[31:16] == $past(hwdata[31:16]);
  endproperty
  a_def_write: assert property (p_def_write)
    else $error("definition write not stored");

  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
    s_fire_halt |=> halt_req && !debug_irq;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt response missing");

  property p_dbg_irq;
    @(posedge hclk) disable iff (!hresetn)
    s_fire_dbg |=> debug_irq && !halt_req;
  endproperty
  a_dbg_irq: assert property (p_dbg_irq)
    else $error("debug interrupt response missing");

  property p_display;
    @(posedge hclk) disable iff (!hresetn)
    fire |=> debug_data_pins[3] ##1 debug_data_pins == 4'h0 || $past(fire);
  endproperty
  a_display: assert property (p_display)
    else $error("trigger not shown on debug pins");

  property p_global_off;
    @(posedge hclk) disable iff (!hresetn)
    state_r == BTL_ARM_L1 && !cfg_l1[`BTL_LV_GLOBAL_EN]
      |=> !debug_data_pins[3] && !halt_req && !debug_irq;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("trigger with level disabled");

  property p_two_level;
    @(posedge hclk) disable iff (!hresetn)
    s_l1_then_l2 |-> !debug_data_pins[3];
  endproperty
  a_two_level: assert property (p_two_level)
    else $error("response after first level only");

  property p_invert;
    @(posedge hclk) disable iff (!hresetn)
    core_valid && cfg_l1 == 14'h3020 && byte_eq == 4'hF |-> !l1_hit;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted data compare hit on equal");

  property p_low_match;
    @(posedge hclk) disable iff (!hresetn)
    core_valid && cfg_l1 == 14'h2004 |-> l1_hit == addr_eq_low;
  endproperty
  a_low_match: assert property (p_low_match)
    else $error("low address match wrong");

endmodule

// >>> sim/btl_core_model.sv
`timescale 1ns/1ns
module btl_core_model (
  input  wire logic        hclk,
  output logic             core_valid,
  output logic      [31:0] core_addr,
  output logic      [31:0] core_data_bus,
  output logic      [31:0] core_pc
);
  initial begin
    core_valid = 1'b0;
    core_addr = 32'h0;
    core_data_bus = 32'h0;
    core_pc = 32'h0;
  end

  // One access per call; buses show inverted junk once released,
  // so a design that samples outside the strobe cannot look right
  task automatic drive(input logic [31:0] a, d, p);
    @(posedge hclk);
    core_valid <= 1'b1;
    core_addr <= a;
    core_data_bus <= d;
    core_pc <= p;
    @(posedge hclk);
    core_valid <= 1'b0;
    core_addr <= ~a;
    core_data_bus <= ~d;
    core_pc <= ~p;
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
`include "btl_regs.svh"
module tb;
  import btl_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  debug_data_pins;
  logic        halt_req;
  logic        debug_irq;
  logic        irq;
  logic        core_valid;
  logic [31:0] core_addr;
  logic [31:0] core_data_bus;
  logic [31:0] core_pc;
  int          miscompares = 0;
  int          checked = 0;

  localparam logic [31:0] EN = 32'h1 << `BTL_LV_GLOBAL_EN;
  localparam logic [31:0] AL = 32'h1 << `BTL_LV_ADDR_LOW;
  localparam logic [31:0] AR = 32'h1 << `BTL_LV_ADDR_RANGE;
  localparam logic [31:0] AI = 32'h1 << `BTL_LV_ADDR_OUT;
  localparam logic [31:0] PE = 32'h1 << `BTL_LV_PC_EN;
  localparam logic [31:0] PI = 32'h1 << `BTL_LV_PC_INV;
  localparam logic [31:0] DINV = 32'h1 << `BTL_LV_DATA_INV;

  // Core data bits covered by data enable i, longword first
  function automatic logic [31:0] lane_mask(input int i);
    case (i)
      0:       lane_mask = 32'hFFFFFFFF;
      1:       lane_mask = 32'h0000FFFF;
      2:       lane_mask = 32'hFFFF0000;
      3:       lane_mask = 32'h000000FF;
      4:       lane_mask = 32'h0000FF00;
      5:       lane_mask = 32'h00FF0000;
      default: lane_mask = 32'hFF000000;
    endcase
  endfunction

  always #5 hclk = ~hclk;

  btl_trigger DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .core_valid, .core_addr, .core_data_bus, .core_pc,
    .debug_data_pins, .halt_req, .debug_irq, .irq);

  btl_core_model core (.hclk, .core_valid, .core_addr, .core_data_bus,
    .core_pc);

  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, e);
  endtask

  // Expected pin code e; halt and debug interrupt follow from it
  task automatic fire(input logic [31:0] a, d, p, input logic [3:0] e);
    core.drive(a, d, p);
    #1;
    check({28'h0, debug_data_pins}, {28'h0, e});
    check({31'h0, halt_req}, {31'h0, e == 4'h9});
    check({31'h0, debug_irq}, {31'h0, e == 4'hA});
  endtask

  task automatic t_regs;
    check({28'h0, debug_data_pins}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    rchk(`BTL_OFS_DEF, 32'h0);
    wr(`BTL_OFS_DEF, 32'hFFFFFFFF);
    rchk(`BTL_OFS_DEF, 32'hFFFF3FFF);
    wr(8'h40, 32'h5A5A5A5A);
    rchk(8'h40, 32'h0);
  endtask

  task automatic t_resp;
    logic [3:0] e;
    wr(`BTL_OFS_ADDR_LOW, 32'h100);
    for (int r = 0; r < 4; r++) begin
      e = 4'h8 | r[3:0];
      wr(`BTL_OFS_DEF, (r << 30) | EN | AL);
      fire(32'h100, 32'hDEAD0000 + r, 32'h0, e);
      fire(32'h104, 32'h0, 32'h0, 4'h0);
    end
    wr(`BTL_OFS_DEF, AL | AR | AI);
    fire(32'h100, 32'h0, 32'h0, 4'h0);
  endtask

  // Bit 0 of one byte flipped at a time; only lanes that cover it may see it
  task automatic t_data;
    logic [31:0] f;
    logic [31:0] c;
    logic [31:0] d;
    logic [3:0]  e;
    wr(`BTL_OFS_DATA_VAL, 32'h11223344);
    for (int i = 0; i < 7; i++)
      for (int v = 0; v < 2; v++) begin
        c = 32'h1 << (`BTL_LV_LONGWORD - i);
        wr(`BTL_OFS_DEF, EN | c | (v ? DINV : 32'h0));
        for (int k = 0; k < 5; k++) begin
          f = (k < 4) ? (32'h1 << (8 * k)) : 32'h0;
          d = 32'h11223344 ^ f;
          e = (((lane_mask(i) & f) == 0) ^ v) ? 4'h8 : 4'h0;
          fire(32'h0, d, 32'h0, e);
        end
      end
  endtask

  task automatic t_addr;
    logic [31:0] a;
    logic [3:0]  e;
    logic        in_r;
    wr(`BTL_OFS_ADDR_HIGH, 32'h1FF);
    for (int m = 0; m < 3; m++) begin
      wr(`BTL_OFS_DEF, EN | (m == 0 ? AL : m == 1 ? AR : AI));
      for (int j = 0; j < 5; j++) begin
        case (j)
          0:       a = 32'h000000FF;
          1:       a = 32'h00000100;
          2:       a = 32'h00000180;
          3:       a = 32'h000001FF;
          default: a = 32'h00000200;
        endcase
        in_r = (j > 0 && j < 4);
        e = (m == 0 ? j == 1 : m == 1 ? in_r : !in_r) ? 4'h8 : 4'h0;
        fire(a, 32'h0, 32'h0, e);
      end
    end
  endtask

  task automatic t_pc;
    wr(`BTL_OFS_PC_BASE, 32'h4000);
    wr(`BTL_OFS_PC_MASK, 32'hFF);
    for (int v = 0; v < 2; v++) begin
      wr(`BTL_OFS_DEF, EN | PE | (v ? PI : 32'h0));
      fire(32'h0, 32'h0, 32'h40AB, v ? 4'h0 : 4'h8);
      fire(32'h0, 32'h0, 32'h5000, v ? 4'h8 : 4'h0);
    end
    wr(`BTL_OFS_DEF, EN | PI);
    fire(32'h0, 32'h0, 32'h5000, 4'h0);
  endtask

  task automatic t_two;
    wr(`BTL_OFS_CLEAR, 32'h3);
    wr(`BTL_OFS_DEF, 32'h40000000 | ((EN | AI) << 16) | EN | AL);
    fire(32'h300, 32'h0, 32'h0, 4'h0);
    rchk(`BTL_OFS_STATE, 32'h1);
    fire(32'h100, 32'h0, 32'h0, 4'h0);
    rchk(`BTL_OFS_STATE, 32'h2);
    fire(32'h300, 32'h0, 32'h0, 4'h9);
    wr(`BTL_OFS_STATUS, 32'h0);
    rchk(`BTL_OFS_STATUS, 32'h3);
    wr(`BTL_OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge hclk);
    #1 check({31'h0, irq}, 32'h1);
    wr(`BTL_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    #1 check({31'h0, irq}, 32'h0);
    wr(`BTL_OFS_IRQ_EN, 32'h2);
    wr(`BTL_OFS_CLEAR, 32'h3);
    rchk(`BTL_OFS_STATUS, 32'h0);
    rchk(`BTL_OFS_CLEAR, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_resp();
    t_data();
    t_addr();
    t_pc();
    t_two();
    tally_and_finish();
  end
endmodule
